// ### src/byte_fifo.sv
// Small valid/ready FIFO for received write bytes
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready = cnt_reg != (AW + 1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = buf_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (ce && push)
			buf_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else if (ce)
		begin
			if (push)
				wr_reg <= AW'(wr_reg + 1'b1);
			if (pop)
				rd_reg <= AW'(rd_reg + 1'b1);
			if (push && !pop)
				cnt_reg <= (AW + 1)'(cnt_reg + 1'b1);
			else if (pop && !push)
				cnt_reg <= (AW + 1)'(cnt_reg - 1'b1);
		end
	end
endmodule

// ### src/eeprom_pkg.sv
// Constants, types and ECC helpers of the serial EEPROM slave
//
// Contract
// R1: ID page write: type 1011b, lock bit clear
// R2: Five low address bits pick ID byte
// R3: Locked ID page: data bytes refused, unchanged
// R4: Lock makes ID page permanently read-only
// R5: Lock: type 1011b, byte write, lock bit set
// R6: Lock data byte needs bit 1 set
// R7: Lock when already locked gets refused
// R8: Six check bits per word, single-bit correction
// R9: Any write rewrites whole word with checks
// R10: No select acknowledge during write cycle
// R11: Reads ignore the write-inhibit input
// R12: Pointer advances after every byte read
// R13: Random read: dummy write, restart, read
// R14: Master ends single read with refusal, Stop
// R15: Current read returns byte at pointer
// R16: Acknowledged byte brings the next byte
// R17: Pointer wraps to zero after last address
// R18: ID read like random read, page bounded
// R19: Lock status: data byte acknowledged if unlocked
// R20: Start discards command, Stop gives standby
// R21: Unacknowledged read byte ends the transfer
// R22: Main array delivered as all ones
// R23: Select: type, straps, direction; mismatch refused
// R24: Write cycle starts only on Stop after slot
// R25: Write inhibit refuses data, skips write
// R26: Page write up to 32 bytes, one row
// R27: ID write pointer wraps in five bits
package eeprom_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int WRITE_TIME_US = 5000;
	localparam int WRITE_CYCLES_DEF = CLK_HZ / 1_000_000 * WRITE_TIME_US;
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_IDENT = 4'hB;
	localparam int PAGE_BYTES = 32;
	localparam int LOCK_SEL_POS = 2;
	localparam int LOCK_DATA_POS = 1;
	localparam int CW_BITS = 38;
	localparam int WORDS_ALL = 1032;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 4;
	localparam logic [31:0] ERASED_DATA = 32'hFFFF_FFFF;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] SLOT_END = 4'h9;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       inhibit;
		logic [2:0] strap;
	} pins_t;
	localparam pins_t PINS_IDLE = 6'h30;

	typedef struct packed {
		logic [5:0]  chk;
		logic [31:0] data;
	} word_t;

	typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WDATA,
		S_RDATA} bus_st_t;
	typedef enum logic [1:0] {K_MAIN, K_IDENT, K_LOCK} cmd_t;
	typedef enum logic [1:0] {W_IDLE, W_READ, W_MERGE, W_WAIT} wr_st_t;

	// Hamming check bits; data fills the non-power-of-two positions
	function automatic logic [5:0] ecc_gen(input logic [31:0] d);
		logic [5:0] c;
		int         k;
		c = '0;
		k = 0;
		for (int p = 1; p <= CW_BITS; p++)
		begin
			if ((p & (p - 1)) != 0)
			begin
				if (d[k])
					c = c ^ 6'(p);
				k = k + 1;
			end
		end
		return c;
	endfunction

	function automatic logic [31:0] ecc_fix(input word_t w);
		logic [5:0]  s;
		logic [31:0] r;
		int          k;
		s = ecc_gen(w.data) ^ w.chk;
		r = w.data;
		k = 0;
		for (int p = 1; p <= CW_BITS; p++)
		begin
			if ((p & (p - 1)) != 0)
			begin
				if (s == 6'(p))
					r[k] = ~r[k];
				k = k + 1;
			end
		end
		return r;
	endfunction

	localparam word_t ERASED_WORD = '{chk: ecc_gen(ERASED_DATA),
		data: ERASED_DATA};
endpackage

// ### src/eeprom_slave.sv
// Two-wire EEPROM slave: decode, ID page, ECC array, write cycle
`timescale 1ns/100ps
module eeprom_slave #(
	parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Serial link
	input  wire logic scl_pin,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	// Straps and control
	input  wire logic write_inhibit_input,
	input  wire logic chip_strap_bit2,
	input  wire logic chip_strap_bit1,
	input  wire logic chip_strap_bit0,
	// Status
	output logic      ident_locked,
	output logic      write_busy
);
	import eeprom_pkg::*;

	pins_t       sync1_reg;
	pins_t       sync2_reg;
	logic        scl_prev_reg;
	logic        sda_prev_reg;
	bus_st_t     state_reg;
	bus_st_t     next_st_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  sh_reg;
	logic [3:0]  hi_reg;
	logic        lock_sel_reg;
	logic        ack_reg;
	logic        id_reg;
	logic        data_acked_reg;
	logic        lock_arm_reg;
	logic [11:0] ptr_reg;
	logic [4:0]  wptr_reg;
	logic [7:0]  tx_reg;
	logic        oe_n_reg;
	logic        fetch_reg;
	logic        load_reg;
	wr_st_t      wst_reg;
	logic [2:0]  widx_reg;
	logic [31:0] timer_reg;
	logic [7:0]  pg_data_reg [PAGE_BYTES];
	logic [31:0] pg_mask_reg;
	logic        locked_reg = 1'b0;
	word_t       mem [WORDS_ALL] = '{default: ERASED_WORD};
	word_t       rd_q_reg;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	logic [7:0]  rx_byte;
	logic        byte_done;
	logic        sel_match;
	logic        wr_ok;
	logic        busy;
	logic        adv_ev;
	logic        ld_ptr;
	logic        go_write;
	logic        commit_done;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_push;
	logic        pop;
	logic        mem_we;
	logic [7:0]  fifo_out_data;
	logic [31:0] fixed_word;
	logic [31:0] merged;
	logic [10:0] rd_idx;
	cmd_t        kind;

	function automatic logic [10:0] mem_idx(input logic id,
		input logic [6:0] row, input logic [2:0] w);
		return id ? {1'b1, 7'h00, w} : {1'b0, row, w};
	endfunction

	// Pin synchronisers and edge history
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= PINS_IDLE;
			sync2_reg <= PINS_IDLE;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else if (ce)
		begin
			sync1_reg <= {scl_pin, sda_in, write_inhibit_input,
				chip_strap_bit2, chip_strap_bit1, chip_strap_bit0};
			sync2_reg <= sync1_reg;
			scl_prev_reg <= sync2_reg.scl;
			sda_prev_reg <= sync2_reg.sda;
		end
	end

	assign scl_rise = sync2_reg.scl && !scl_prev_reg;
	assign scl_fall = !sync2_reg.scl && scl_prev_reg;
	assign start_ev = sync2_reg.scl && scl_prev_reg && sda_prev_reg
		&& !sync2_reg.sda;
	assign stop_ev = sync2_reg.scl && scl_prev_reg && !sda_prev_reg
		&& sync2_reg.sda;
	assign rx_byte = {sh_reg[6:0], sync2_reg.sda};
	assign byte_done = scl_rise && cnt_reg == BIT_LAST
		&& state_reg inside {S_DEV, S_AHI, S_ALO, S_WDATA};
	assign busy = wst_reg != W_IDLE;
	assign kind = !id_reg ? K_MAIN : (lock_sel_reg ? K_LOCK : K_IDENT);
	assign sel_match = (rx_byte[7:4] == TYPE_ARRAY    // R23
		|| rx_byte[7:4] == TYPE_IDENT)
		&& rx_byte[3:1] == sync2_reg.strap && !busy;  // R10
	assign wr_ok = !sync2_reg.inhibit                  // R25
		&& !(kind != K_MAIN && locked_reg)           // R3 R7 R19
		&& (kind == K_LOCK || fifo_in_ready);
	assign fifo_push = byte_done && state_reg == S_WDATA && wr_ok
		&& kind != K_LOCK;
	assign adv_ev = scl_rise && state_reg == S_RDATA && cnt_reg == ACK_SLOT;
	assign ld_ptr = byte_done && state_reg == S_ALO;
	// The Stop's own clock rise has already counted one bit
	assign go_write = stop_ev && state_reg == S_WDATA && cnt_reg == 4'h1
		&& data_acked_reg && !busy;                  // R24
	assign commit_done = wst_reg == W_WAIT
		&& timer_reg == WRITE_CYCLES - 1;
	assign pop = fifo_out_valid && !busy;

	// Byte framing, acknowledge decisions and command decode
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= S_IDLE;
			next_st_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			hi_reg <= 4'h0;
			lock_sel_reg <= 1'b0;
			ack_reg <= 1'b0;
			id_reg <= 1'b0;
			data_acked_reg <= 1'b0;
			lock_arm_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (start_ev)
			begin
				state_reg <= S_DEV;  // R20
				cnt_reg <= 4'h0;
				ack_reg <= 1'b0;
				data_acked_reg <= 1'b0;
				lock_arm_reg <= 1'b0;
			end
			else if (stop_ev)
			begin
				state_reg <= S_IDLE;  // R20
				cnt_reg <= 4'h0;
				ack_reg <= 1'b0;
			end
			else if (state_reg != S_IDLE)
			begin
				if (scl_rise && cnt_reg != SLOT_END)
				begin
					cnt_reg <= cnt_reg + 4'h1;
					sh_reg <= rx_byte;
					// Ack survives the first rise, which may belong to a Stop
					if (cnt_reg == 4'h1)
						data_acked_reg <= 1'b0;
					if (adv_ev && sync2_reg.sda)
						state_reg <= S_IDLE;  // R21 R14
				end
				if (byte_done)
				begin
					case (state_reg)
					S_DEV:
					begin
						ack_reg <= sel_match;
						if (!sel_match)
							next_st_reg <= S_IDLE;
						else if (rx_byte[0])
							next_st_reg <= S_RDATA;  // R15 R13 R11
						else
							next_st_reg <= S_AHI;
						if (sel_match)
							id_reg <= rx_byte[7:4] == TYPE_IDENT;  // R18
					end
					S_AHI:
					begin
						ack_reg <= 1'b1;
						hi_reg <= rx_byte[3:0];
						lock_sel_reg <= rx_byte[LOCK_SEL_POS];  // R1 R5
						next_st_reg <= S_ALO;
					end
					S_ALO:
					begin
						ack_reg <= 1'b1;
						next_st_reg <= S_WDATA;
					end
					S_WDATA:
					begin
						ack_reg <= wr_ok;
						data_acked_reg <= wr_ok;
						if (kind == K_LOCK && wr_ok)
							lock_arm_reg <= rx_byte[LOCK_DATA_POS];  // R6
						next_st_reg <= S_WDATA;
					end
					default:
					begin
						ack_reg <= 1'b0;
						next_st_reg <= S_IDLE;
					end
					endcase
				end
				if (scl_fall && cnt_reg == SLOT_END)
				begin
					cnt_reg <= 4'h0;
					state_reg <= next_st_reg;
				end
			end
		end
	end

	// Open-drain data line: low enable pulls the line low
	always_ff @(posedge clk)
	begin
		if (rst)
			oe_n_reg <= 1'b1;
		else if (ce)
		begin
			if (start_ev || stop_ev || state_reg == S_IDLE)
				oe_n_reg <= 1'b1;
			else if (scl_fall)
			begin
				case (cnt_reg)
				ACK_SLOT:
					oe_n_reg <= state_reg == S_RDATA || !ack_reg;
				SLOT_END:
					oe_n_reg <= next_st_reg == S_RDATA ? tx_reg[7] : 1'b1;
				default:
					oe_n_reg <= state_reg == S_RDATA
						? tx_reg[3'd7 - cnt_reg[2:0]] : 1'b1;
				endcase
			end
		end
	end

	// Address pointer
	always_ff @(posedge clk)
	begin
		if (rst)
			ptr_reg <= 12'h000;
		else if (ce)
		begin
			if (commit_done)
				ptr_reg <= {ptr_reg[11:5], wptr_reg};
			else if (ld_ptr)
				ptr_reg <= {hi_reg, rx_byte};  // R2
			else if (adv_ev)
				ptr_reg <= ptr_reg + 12'h001;  // R12 R16 R17
		end
	end

	// Read fetch: memory read, then load of the corrected byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fetch_reg <= 1'b0;
			load_reg <= 1'b0;
			tx_reg <= 8'hFF;
		end
		else if (ce)
		begin
			fetch_reg <= (byte_done && state_reg == S_DEV && sel_match
				&& rx_byte[0]) || (adv_ev && !sync2_reg.sda);  // R16
			load_reg <= fetch_reg;
			if (load_reg)
				tx_reg <= fixed_word[{ptr_reg[1:0], 3'b000} +: 8];  // R8
		end
	end

	byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.in_valid (fifo_push),
		.in_ready (fifo_in_ready),
		.in_data  (rx_byte),
		.out_valid(fifo_out_valid),
		.out_ready(!busy),
		.out_data (fifo_out_data)
	);

	// Page latch fed from the FIFO
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wptr_reg <= 5'h00;
			pg_mask_reg <= 32'h0000_0000;
		end
		else if (ce)
		begin
			// Polling Starts must not drop bytes still being merged
			if ((start_ev && !busy) || commit_done)
				pg_mask_reg <= 32'h0000_0000;  // R20
			else if (pop)
			begin
				pg_data_reg[wptr_reg] <= fifo_out_data;
				pg_mask_reg[wptr_reg] <= 1'b1;
			end
			if (ld_ptr)
				wptr_reg <= rx_byte[4:0];
			else if (pop)
				wptr_reg <= wptr_reg + 5'h01;  // R26 R27
		end
	end

	assign rd_idx = busy ? mem_idx(id_reg, ptr_reg[11:5], widx_reg)
		: mem_idx(id_reg, ptr_reg[11:5], ptr_reg[4:2]);
	assign fixed_word = ecc_fix(rd_q_reg);  // R8
	assign mem_we = wst_reg == W_MERGE
		&& pg_mask_reg[{widx_reg, 2'b00} +: 4] != 4'h0;

	// Whole-word merge of the latched bytes
	always_comb
	begin
		merged = fixed_word;
		for (int b = 0; b < 4; b++)
		begin
			if (pg_mask_reg[{widx_reg, 2'(b)}])
				merged[8 * b +: 8] = pg_data_reg[{widx_reg, 2'(b)}];  // R9
		end
	end

	// Array of words with check bits, erased to all ones
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			if (mem_we)
				mem[rd_idx] <= '{chk: ecc_gen(merged), data: merged};  // R9 R22
			rd_q_reg <= mem[rd_idx];
		end
	end

	// Internal write cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wst_reg <= W_IDLE;
			widx_reg <= 3'h0;
			timer_reg <= 32'h0000_0000;
		end
		else if (ce)
		begin
			timer_reg <= timer_reg + 32'h0000_0001;
			case (wst_reg)
			W_IDLE:
			begin
				timer_reg <= 32'h0000_0000;
				widx_reg <= 3'h0;
				if (go_write)
				begin
					if (kind == K_LOCK)
					begin
						if (lock_arm_reg)
							locked_reg <= 1'b1;  // R4 R5
						wst_reg <= W_WAIT;
					end
					else
						wst_reg <= W_READ;
				end
			end
			W_READ:
				wst_reg <= W_MERGE;
			W_MERGE:
			begin
				widx_reg <= widx_reg + 3'h1;
				wst_reg <= widx_reg == 3'h7 ? W_WAIT : W_READ;
			end
			W_WAIT:
			begin
				if (commit_done)
					wst_reg <= W_IDLE;
			end
			default:
				wst_reg <= W_IDLE;
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_reg;
	assign ident_locked = locked_reg;
	assign write_busy = busy;

	chk_busy_silent: assert property (@(posedge clk) disable iff (rst)
		busy |-> oe_n_reg) else $error("line driven during write");  // R10
	chk_lock_sticky: assert property (@(posedge clk) disable iff (rst)
		$past(locked_reg) |-> locked_reg) else $error("lock lost");  // R4
	chk_locked_nack: assert property (@(posedge clk) disable iff (rst)  // R3
		ce && byte_done && state_reg == S_WDATA && kind != K_MAIN
		&& locked_reg |=> !ack_reg) else $error("locked page acked");
	chk_inhibit_nack: assert property (@(posedge clk) disable iff (rst)  // R25
		ce && byte_done && state_reg == S_WDATA && sync2_reg.inhibit
		|=> !ack_reg && !data_acked_reg) else $error("inhibit acked");
	chk_strap_nack: assert property (@(posedge clk) disable iff (rst)  // R23
		ce && byte_done && state_reg == S_DEV
		&& rx_byte[3:1] != sync2_reg.strap
		|=> !ack_reg && next_st_reg == S_IDLE) else $error("bad select");
	chk_read_select: assert property (@(posedge clk) disable iff (rst)  // R11
		ce && byte_done && state_reg == S_DEV && rx_byte[0] && !busy
		&& rx_byte[7:4] == TYPE_ARRAY && rx_byte[3:1] == sync2_reg.strap
		|=> ack_reg && next_st_reg == S_RDATA ##1 load_reg)
		else $error("read select refused");
	chk_ptr_step: assert property (@(posedge clk) disable iff (rst)  // R12
		ce && adv_ev && !commit_done
		|=> ptr_reg == $past(ptr_reg) + 12'h001) else $error("no step");
	chk_nack_idle: assert property (@(posedge clk) disable iff (rst)  // R21
		ce && adv_ev && sync2_reg.sda && !start_ev && !stop_ev
		|=> state_reg == S_IDLE) else $error("read not ended");
	chk_stray_stop: assert property (@(posedge clk) disable iff (rst)  // R24
		ce && stop_ev && !busy
		&& !(state_reg == S_WDATA && cnt_reg == 4'h1)
		|=> !busy) else $error("write on stray stop");
	chk_start_reset: assert property (@(posedge clk) disable iff (rst)  // R20
		ce && start_ev && !busy
		|=> state_reg == S_DEV && pg_mask_reg == 32'h0)
		else $error("start did not reset");
endmodule

// ### tb/i2c_master_model.sv
// Bus master model that clocks the serial link
`timescale 1ns/100ps
module i2c_master_model (
	// Clock
	input  wire logic clk,
	// Serial link
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Clock stands high between frames
	task automatic start();
		sda_low <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(6);
	endtask

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(2);
		#1 r = sda;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, r);
	endtask
endmodule

// ### tb/tb_top.sv
// Bench of the EEPROM slave against a byte-level model
`timescale 1ns/100ps
module tb_top;
	import eeprom_pkg::*;
	localparam int WCYC = 200;
	logic        clk, rst, ce, inhibit, scl, sda_low, sda_w;
	logic        sda_out, sda_oe_n, ident_locked, write_busy, locked;
	logic [2:0]  strap;
	logic [31:0] seed;
	logic [7:0]  mem [4096];
	logic [7:0]  idp [32];
	int          ptr, miscompares, n_compared, busy_cnt, busy_len, busy_eps;

	// Open-drain wire with pull-up
	assign sda_w = ~sda_low & (sda_oe_n | sda_out);

	eeprom_slave #(.WRITE_CYCLES(WCYC)) dut (
		.clk                 (clk),
		.rst                 (rst),
		.ce                  (ce),
		.scl_pin             (scl),
		.sda_in              (sda_w),
		.sda_out             (sda_out),
		.sda_oe_n            (sda_oe_n),
		.write_inhibit_input (inhibit),
		.chip_strap_bit2     (strap[2]),
		.chip_strap_bit1     (strap[1]),
		.chip_strap_bit0     (strap[0]),
		.ident_locked        (ident_locked),
		.write_busy          (write_busy)
	);
	i2c_master_model m (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));

	initial
		clk = 1'b0;
	always #12.5 clk = ~clk;

	// Length and number of write cycles
	always @(posedge clk)
	begin
		if (write_busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
		else if (busy_cnt != 0)
		begin
			busy_len <= busy_cnt;
			busy_eps <= busy_eps + 1;
			busy_cnt <= 0;
		end
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic check(input string w, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic sel(input logic [3:0] ty, input logic rw, output logic a);
		m.start();
		m.wbyte({ty, strap, rw}, a);
	endtask

	task automatic addr(input logic [3:0] ty, input logic [7:0] hi, lo);
		logic a;
		sel(ty, 1'b0, a);
		check("select", a, 1'b1);
		m.wbyte(hi, a);
		check("addr hi", a, 1'b1);
		m.wbyte(lo, a);
		check("addr lo", a, 1'b1);
	endtask

	task automatic wr(input logic [3:0] ty, input logic [7:0] hi, lo,
		input int n, input logic [7:0] d0);
		logic       a, ex, lk, lc;
		logic [7:0] d;
		logic [4:0] o;
		int         eps;
		ex = ~inhibit & ~(ty == TYPE_IDENT && locked);
		lc = ty == TYPE_IDENT && hi[LOCK_SEL_POS];
		lk = 1'b0;
		eps = busy_eps;
		addr(ty, hi, lo);
		for (int i = 0; i < n; i++)
		begin
			d = (i == 0) ? d0 : rnd();
			o = lo[4:0] + 5'(i);
			m.wbyte(d, a);
			check("data ack", a, ex);
			if (ex && ty == TYPE_ARRAY)
				mem[{hi[3:0], lo[7:5], o}] = d;
			else if (ex && !lc)
				idp[o] = d;
			else if (ex)
				lk = d[LOCK_DATA_POS];
		end
		m.stop();
		if (ex && ty == TYPE_ARRAY)
			ptr = {hi[3:0], lo[7:5], o + 5'h1};
		if (ex && !lc)
		begin
			sel(TYPE_ARRAY, 1'b0, a);
			check("busy select", a, 1'b0);
			for (int k = 0; k < 10 && !a; k++)
				sel(TYPE_ARRAY, 1'b0, a);
			check("poll ack", a, 1'b1);
			m.stop();
		end
		m.tick(lc ? WCYC + 20 : 4);
		locked = locked | lk;
		check("locked", ident_locked, locked);
		if (!lc)
			check("write cycles", busy_eps - eps, 32'(ex));
		if (ex && !lc)
			check("busy length", busy_len, WCYC);
	endtask

	task automatic rd(input logic [3:0] ty, input logic [7:0] hi, lo,
		input int n, input logic cur);
		logic       a;
		logic [7:0] d;
		int         p;
		p = cur ? ptr : {hi[3:0], lo};
		if (!cur)
			addr(ty, hi, lo);
		sel(ty, 1'b1, a);
		check("read select", a, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			m.rbyte(i < n - 1, d);
			check("read", d, ty == TYPE_ARRAY ? mem[p] : idp[p[4:0]]);
			p = (p + 1) % 4096;
		end
		m.rbyte(1'b0, d);
		check("released", d, 8'hFF);
		m.stop();
		if (ty == TYPE_ARRAY)
			ptr = p;
	endtask

	task automatic lkstat();
		logic a;
		int   eps;
		eps = busy_eps;
		addr(TYPE_IDENT, 8'h00, 8'h00);
		m.wbyte(rnd(), a);
		check("lock status", a, !locked);
		m.start();
		m.stop();
		m.tick(WCYC);
		check("truncated", busy_eps, eps);
	endtask

	initial
	begin
		logic       a;
		logic [7:0] h, l;
		seed = 32'h942F63A4;
		{rst, ce, inhibit, locked} = 4'hC;
		{ptr, busy_cnt, busy_len, busy_eps, miscompares, n_compared} = '0;
		strap = 3'(rnd());
		foreach (mem[i]) mem[i] = 8'hFF;
		foreach (idp[i]) idp[i] = 8'hFF;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		m.tick(12);
		check("busy", write_busy, 1'b0);
		check("drive", sda_oe_n, 1'b1);
		check("line value", sda_out, 1'b0);
		for (int k = 0; k < 128; k++)
		begin
			m.start();
			m.wbyte(8'(k << 1), a);
			check("code", a, k[2:0] == strap && k[6:4] == 3'h5);
			m.stop();
		end
		rd(TYPE_ARRAY, 8'h0F, 8'hFE, 2, 1'b0);
		wr(TYPE_ARRAY, 8'hF0, 8'h00, 4, rnd());
		rd(TYPE_ARRAY, 8'h0F, 8'hFF, 3, 1'b0);
		wr(TYPE_ARRAY, 8'h01, 8'h3E, 3, rnd());
		rd(TYPE_ARRAY, 8'h00, 8'h00, 2, 1'b1);
		rd(TYPE_ARRAY, 8'h01, 8'h3E, 3, 1'b0);
		rd(TYPE_ARRAY, 8'h01, 8'h20, 1, 1'b0);
		inhibit <= 1'b1;
		m.tick(1);
		wr(TYPE_ARRAY, 8'h00, 8'h01, 2, rnd());
		rd(TYPE_ARRAY, 8'h00, 8'h00, 4, 1'b0);
		inhibit <= 1'b0;
		m.tick(1);
		lkstat();
		wr(TYPE_IDENT, 8'hFB, 8'hFF, 3, rnd());
		rd(TYPE_IDENT, 8'h5A, 8'hDF, 1, 1'b0);
		rd(TYPE_IDENT, 8'hF8, 8'h00, 3, 1'b0);
		wr(TYPE_IDENT, 8'h04, 8'h00, 1, 8'hFD);
		wr(TYPE_IDENT, 8'hF4, 8'h77, 1, 8'h02);
		lkstat();
		wr(TYPE_IDENT, 8'h00, 8'h10, 2, rnd());
		wr(TYPE_IDENT, 8'h04, 8'h00, 1, 8'hFF);
		rd(TYPE_IDENT, 8'h00, 8'h1E, 2, 1'b0);
		h = rnd();
		l = rnd() & 8'hFC;
		wr(TYPE_ARRAY, h, l, 4, rnd());
		rd(TYPE_ARRAY, h, l, 4, 1'b0);
		summarize();
	end

	// Cuts a hang short
	initial
	begin
		repeat (90000) @(posedge clk);
		check("finished in time", 1'b0, 1'b1);
		summarize();
	end
endmodule
